/* File: verilog/sfs_status_readout.sv */
// Serial output word selection, fault latching and read-clear for the status readout
`timescale 1ns/1ps
module sfs_status_readout #(
  parameter int             OPEN_ON_SLOW = sfs_pkg::OPEN_ON_SLOW_CYC,
  parameter int             OPEN_ON_FAST = sfs_pkg::OPEN_ON_FAST_CYC,
  parameter logic [7:0]     PART_CODE    = 8'h5a   // Arbitrary value
) (
  input  wire logic                                   sys_clk_i,
  input  wire logic                                   rst_n_i,
  input  wire logic                                   spi_cs_n_i,
  input  wire logic                                   spi_sclk_i,
  input  wire logic                                   spi_si_i,
  output logic                                        spi_so_o,
  output logic                                        spi_so_oe_n_o,
  input  wire logic                                   fail_state_indicator_i,
  input  wire logic                                   serial_regs_reset_i,
  input  wire sfs_pkg::sfs_chan_flags_t [sfs_pkg::NUM_CH-1:0] chan_raw_i,
  input  wire sfs_pkg::sfs_dev_raw_t                  dev_raw_i,
  input  wire sfs_pkg::sfs_io_raw_t                   io_raw_i,
  output logic                                        open_on_deglitch_select_o
);
  import sfs_pkg::*;

  localparam int CH_W   = $bits(sfs_chan_flags_t);
  localparam int DEV_W  = $bits(sfs_dev_raw_t);
  localparam int IO_W   = $bits(sfs_io_raw_t);
  localparam int SYNC_W = 5 + NUM_CH * CH_W + DEV_W + IO_W;
  // Chip select idles high; an all-zero reset would fake a frame edge
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {1'b1, {(SYNC_W - 1){1'b0}}};

  // Every pin input passes two flops; stage one feeds stage two only
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic              cs_q;
  logic              sclk_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_a <= SYNC_IDLE;
      sync_b <= SYNC_IDLE;
    end else begin
      sync_a <= {spi_cs_n_i, spi_sclk_i, spi_si_i, fail_state_indicator_i, serial_regs_reset_i,
                 chan_raw_i, dev_raw_i, io_raw_i};
      sync_b <= sync_a;
    end
  end

  logic                                cs_n_s;
  logic                                sclk_s;
  logic                                si_s;
  logic                                fail_s;
  logic                                regs_rst_s;
  sfs_chan_flags_t [NUM_CH-1:0]        chan_s;
  sfs_dev_raw_t                        dev_s;
  sfs_io_raw_t                         io_s;

  assign {cs_n_s, sclk_s, si_s, fail_s, regs_rst_s, chan_s, dev_s, io_s} = sync_b;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_q   <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      cs_q   <= cs_n_s;
      sclk_q <= sclk_s;
    end
  end

  logic frame_start;
  logic frame_end;
  logic sclk_rise;
  logic sclk_fall;

  assign frame_start = cs_q & ~cs_n_s;
  assign frame_end   = ~cs_q & cs_n_s;
  assign sclk_rise   = ~cs_n_s & ~sclk_q & sclk_s;
  assign sclk_fall   = ~cs_n_s & sclk_q & ~sclk_s;

  // Frame shifting
  logic [WORD_W-1:0] rx_word;
  logic [WORD_W-1:0] tx_word;
  logic [CNT_W-1:0]  bit_cnt;
  logic [ADDR_W-1:0] frame_sel;
  logic [ADDR_W-1:0] out_sel;
  logic              frame_ok;
  logic [WORD_W-1:0] out_word;

  assign frame_ok = frame_end & (bit_cnt == FRAME_BITS);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_word <= WORD_ZERO;
      bit_cnt <= '0;
    end else if (frame_start) begin
      bit_cnt <= '0;
    end else if (sclk_rise) begin
      rx_word <= {rx_word[WORD_W-2:0], si_s};
      if (bit_cnt != FRAME_BITS + 5'h01) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_word   <= WORD_ZERO;
      frame_sel <= SEL_DEFAULT;
    end else if (frame_start) begin
      tx_word   <= out_word;
      frame_sel <= out_sel;
    end else if (sclk_fall) begin
      tx_word <= {tx_word[WORD_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spi_so_o      <= 1'b0;
      spi_so_oe_n_o <= 1'b1;
    end else begin
      spi_so_o      <= tx_word[WORD_W-1];
      spi_so_oe_n_o <= cs_n_s;
    end
  end

  // Selection state, committed only on a whole 16-bit frame
  logic              select_persist_bit;
  logic              init_write;

  assign init_write = frame_ok & (rx_word[WORD_W-1:SI_ADDR_LO] == WR_ADDR_INIT1);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_sel                   <= SEL_DEFAULT;
      select_persist_bit        <= 1'b0;
      open_on_deglitch_select_o <= 1'b0;
    end else if (regs_rst_s) begin
      out_sel                   <= SEL_DEFAULT;
      select_persist_bit        <= 1'b0;
      open_on_deglitch_select_o <= 1'b0;
    end else if (init_write) begin
      out_sel                   <= rx_word[SI_SEL_LO +: ADDR_W];
      select_persist_bit        <= rx_word[SI_PERSIST_BIT];
      open_on_deglitch_select_o <= rx_word[SI_DGL_BIT];
    end else if (frame_ok && !select_persist_bit) begin
      out_sel <= SEL_DEFAULT;
    end
    // Persist set: selection simply stays
  end

  // Read-clear strobes act on the word that left during the frame just ended
  function automatic logic read_of(input logic [ADDR_W-1:0] addr);
    return frame_ok && (frame_sel == addr);
  endfunction

  // Open-load deglitch counters; the level must stay high for the full time
  logic [NUM_CH-1:0] off_dgl;
  logic [NUM_CH-1:0] on_dgl;
  logic [DGL_W-1:0]  on_limit;

  assign on_limit = open_on_deglitch_select_o ? DGL_W'(OPEN_ON_FAST) : DGL_W'(OPEN_ON_SLOW);

  sfs_chan_flags_t [NUM_CH-1:0] chan_lat;
  logic [NUM_CH-1:0]            ch_read;
  logic [NUM_CH-1:0]            quick_flag;
  logic [2:0]                   oc_prev [NUM_CH];

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [DGL_W-1:0] off_cnt;
    logic [DGL_W-1:0] on_cnt;
    sfs_chan_flags_t  set;

    assign ch_read[c] = read_of(ADDR_CH_FIRST + ADDR_W'(c));

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        off_cnt <= '0;
        on_cnt  <= '0;
      end else begin
        off_cnt <= chan_s[c].open_off_flag ?
                   ((off_cnt == DGL_W'(OPEN_OFF_DGL_CYC)) ? off_cnt : off_cnt + 1'b1) : '0;
        on_cnt  <= chan_s[c].open_on_flag ?
                   ((on_cnt >= on_limit) ? on_cnt : on_cnt + 1'b1) : '0;
      end
    end

    assign off_dgl[c] = (off_cnt == DGL_W'(OPEN_OFF_DGL_CYC) - 1'b1) & chan_s[c].open_off_flag;
    assign on_dgl[c]  = (on_cnt == on_limit - 1'b1) & chan_s[c].open_on_flag;

    always_comb begin
      set                        = '0;
      set.overtemp_shutdown_flag = chan_s[c].overtemp_shutdown_flag;
      set.overtemp_warning_flag  = chan_s[c].overtemp_warning_flag;
      set.open_on_flag           = on_dgl[c];
      set.open_off_flag          = off_dgl[c];
    end

    // Code is set by a fresh code other than none or unused, so the latest one wins; otherwise a read clears it
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        oc_prev[c] <= SFS_OC_NONE;
      end else begin
        oc_prev[c] <= chan_s[c].overcurrent_code;
      end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        chan_lat[c] <= '0;
      end else begin
        // A set arriving with the read-clear survives
        chan_lat[c].overtemp_shutdown_flag <= set.overtemp_shutdown_flag |
                                              (chan_lat[c].overtemp_shutdown_flag & ~ch_read[c]);
        chan_lat[c].overtemp_warning_flag  <= set.overtemp_warning_flag |
                                              (chan_lat[c].overtemp_warning_flag & ~ch_read[c]);
        chan_lat[c].open_on_flag           <= set.open_on_flag |
                                              (chan_lat[c].open_on_flag & ~ch_read[c]);
        chan_lat[c].open_off_flag          <= set.open_off_flag |
                                              (chan_lat[c].open_off_flag & ~ch_read[c]);
        if (chan_s[c].overcurrent_code != SFS_OC_NONE &&
            chan_s[c].overcurrent_code != SFS_OC_UNUSED &&
            chan_s[c].overcurrent_code != oc_prev[c]) begin
          chan_lat[c].overcurrent_code <= chan_s[c].overcurrent_code;
        end else if (ch_read[c]) begin
          chan_lat[c].overcurrent_code <= SFS_OC_NONE;
        end
      end
    end

    assign quick_flag[c] = |chan_lat[c];
  end

  // Device flags
  logic dev_read;
  logic test_lat;
  logic ov_lat;
  logic uv_lat;
  logic pump_lat;
  logic pwm_clock_fault_flag_lat;
  logic serial_lat;
  logic regs_cleared_flag;

  assign dev_read = read_of(ADDR_DEVICE);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      test_lat          <= 1'b0;
      ov_lat            <= 1'b0;
      uv_lat            <= 1'b0;
      pump_lat          <= 1'b0;
      pwm_clock_fault_flag_lat          <= 1'b0;
      serial_lat        <= 1'b0;
      regs_cleared_flag <= 1'b1;
    end else begin
      test_lat          <= dev_s.test_entry_flag | (test_lat & ~dev_read);
      ov_lat            <= dev_s.overvoltage_flag | (ov_lat & ~dev_read);
      uv_lat            <= dev_s.undervoltage_flag | (uv_lat & ~dev_read);
      pump_lat          <= dev_s.pump_fault_flag | (pump_lat & ~dev_read);
      pwm_clock_fault_flag_lat          <= dev_s.pwm_clock_fault_flag | (pwm_clock_fault_flag_lat & ~dev_read);
      // A frame of other than 16 bits, shorter or longer, counts as a serial fault
      serial_lat        <= (frame_end & ~frame_ok) | (serial_lat & ~dev_read);
      regs_cleared_flag <= regs_rst_s | (regs_cleared_flag & ~dev_read);
    end
  end

  // Global flags track the latches, so they fall once every detail is read
  logic device_fault_summary;
  logic overload_summary;
  logic open_load_summary;
  logic [2:0] glob;
  logic [QUICK_W-1:0] channel_quick_flags;

  always_comb begin
    overload_summary  = 1'b0;
    open_load_summary = 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      overload_summary  = overload_summary | chan_lat[c].overtemp_shutdown_flag |
                          (|chan_lat[c].overcurrent_code);
      open_load_summary = open_load_summary | chan_lat[c].open_on_flag | chan_lat[c].open_off_flag;
    end
  end

  assign device_fault_summary = regs_cleared_flag | uv_lat | ov_lat | pump_lat | pwm_clock_fault_flag_lat | test_lat;
  assign glob                 = {device_fault_summary, overload_summary, open_load_summary};
  assign channel_quick_flags  = QUICK_W'(quick_flag);

  // Output word assembly; reserved positions stay zero
  function automatic logic [WORD_W-1:0] head(input logic [ADDR_W-1:0] addr, input logic with_glob);
    logic [WORD_W-1:0] w;
    w                            = WORD_ZERO;
    w[SO_ADDR_LO +: ADDR_W]      = addr;
    w[SO_FAIL_BIT]               = fail_s;
    w[SO_GLOB_LO +: 3]           = with_glob ? glob : 3'b000;
    return w;
  endfunction

  always_comb begin
    out_word = WORD_ZERO;
    unique case (out_sel)
      SEL_DEFAULT, ADDR_QUICK: begin
        out_word       = head(ADDR_QUICK, 1'b1);
        out_word[7:0]  = {pump_lat, regs_cleared_flag, pwm_clock_fault_flag_lat, channel_quick_flags};
      end
      ADDR_DEVICE: begin
        out_word       = head(ADDR_DEVICE, 1'b1);
        out_word[4:0]  = {test_lat, ov_lat, uv_lat, serial_lat, dev_s.limp_input_state};
      end
      ADDR_IO: begin
        out_word                = head(ADDR_IO, 1'b0);
        out_word[SO_TOGG_BIT]   = |io_s.toggle_inputs;
        out_word[SO_CTRL_LO +: 4] = io_s.control_input_state;
        out_word[4:0]           = io_s.output_level_bit;
      end
      ADDR_PART: begin
        out_word       = head(ADDR_PART, 1'b0);
        out_word[7:0]  = dev_s.undervoltage_flag ? PART_CODE_UV : PART_CODE;
      end
      default: begin
        if (out_sel >= ADDR_CH_FIRST && out_sel <= ADDR_CH_LAST) begin
          out_word                  = head(out_sel, 1'b1);
          out_word[CH_W-1:0]        = chan_lat[out_sel - ADDR_CH_FIRST];
        end
      end
    endcase
  end

endmodule // sfs_status_readout

/* File: verilog/sfs_pkg.sv */
// Shared constants and carrier types for the serial fault status readout
package sfs_pkg;

  localparam int WORD_W   = 16;
  localparam int ADDR_W   = 4;
  localparam int NUM_CH   = 4;
  localparam int QUICK_W  = 5;
  localparam int CNT_W    = 5;
  localparam int DGL_W    = 22;

  // Output word selection codes; all but SEL_DEFAULT are also the address nibble in bits 15:12
  localparam logic [3:0] SEL_DEFAULT   = 4'h0;
  localparam logic [3:0] ADDR_QUICK    = 4'h1;
  localparam logic [3:0] ADDR_CH_FIRST = 4'h2;
  localparam logic [3:0] ADDR_CH_LAST  = 4'h5;
  localparam logic [3:0] ADDR_DEVICE   = 4'h7;
  localparam logic [3:0] ADDR_IO       = 4'h8;
  localparam logic [3:0] ADDR_PART     = 4'h9;

  // Incoming word layout: address nibble, then the first initialization fields
  localparam logic [3:0] WR_ADDR_INIT1 = 4'h0;
  localparam int SI_ADDR_LO     = 12;
  localparam int SI_SEL_LO      = 0;
  localparam int SI_PERSIST_BIT = 4;
  localparam int SI_DGL_BIT     = 5;

  // Output word field positions
  localparam int SO_ADDR_LO  = 12;
  localparam int SO_FAIL_BIT = 11;
  localparam int SO_GLOB_LO  = 8;
  localparam int SO_TOGG_BIT = 9;
  localparam int SO_CTRL_LO  = 5;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] PART_CODE_UV = 8'h00;
  localparam logic [4:0] FRAME_BITS   = 5'h10;

  // Timing
  localparam int CLK_PERIOD_NS      = 25;
  localparam int OPEN_OFF_DGL_NS    = 3300;
  localparam int OPEN_ON_SLOW_DGL_US = 64;
  localparam int OPEN_ON_FAST_DGL_US = 2;
  localparam int OPEN_OFF_DGL_CYC   = (OPEN_OFF_DGL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OPEN_ON_SLOW_CYC   = OPEN_ON_SLOW_DGL_US * 1000000 / CLK_PERIOD_NS;
  localparam int OPEN_ON_FAST_CYC   = OPEN_ON_FAST_DGL_US * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    SFS_OC_NONE   = 3'b000,
    SFS_OC_WIN1   = 3'b001,
    SFS_OC_WIN2   = 3'b010,
    SFS_OC_WIN3   = 3'b011,
    SFS_OC_LOW    = 3'b100,
    SFS_OC_NOWIN  = 3'b101,
    SFS_OC_SEVERE = 3'b110,
    SFS_OC_UNUSED = 3'b111
  } sfs_oc_code_t;

  // Per-channel flags, packed in the order of the channel word bits 6:0
  typedef struct packed {
    logic       overtemp_shutdown_flag;
    logic       overtemp_warning_flag;
    logic [2:0] overcurrent_code;
    logic       open_on_flag;
    logic       open_off_flag;
  } sfs_chan_flags_t;

  typedef struct packed {
    logic test_entry_flag;
    logic overvoltage_flag;
    logic undervoltage_flag;
    logic pump_fault_flag;
    logic pwm_clock_fault_flag;
    logic limp_input_state;
  } sfs_dev_raw_t;

  typedef struct packed {
    logic [3:0] toggle_inputs;
    logic [3:0] control_input_state;
    logic [4:0] output_level_bit;
  } sfs_io_raw_t;

endpackage

/* File: bench/sfs_checker.sv */
// Port-level assertions for the status readout, bound to its top module
`timescale 1ns/1ps
module sfs_checker #(
  parameter logic [7:0] PART_CODE = 8'h00
) (
  input wire logic                 sys_clk_i,
  input wire logic                 rst_n_i,
  input wire logic                 spi_cs_n_i,
  input wire logic                 spi_sclk_i,
  input wire logic                 spi_so_o,
  input wire logic                 spi_so_oe_n_o,
  input wire logic                 fail_state_indicator_i,
  input wire sfs_pkg::sfs_dev_raw_t dev_raw_i,
  input wire sfs_pkg::sfs_io_raw_t  io_raw_i
);
  import sfs_pkg::*;
  logic        sclk_q;
  logic        cs_q;
  logic [15:0] word;
  logic [4:0]  nbits;
  logic [3:0]  gap;
  logic        done;
  // Raw one-flop view: a fall is seen before the design moves SO
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
    end else begin
      sclk_q <= spi_sclk_i;
      cs_q   <= spi_cs_n_i;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word  <= WORD_ZERO;
      nbits <= 5'h00;
    end else if (cs_q && !spi_cs_n_i) begin
      nbits <= 5'h00;
    end else if (sclk_q && !spi_sclk_i) begin
      word  <= {word[14:0], spi_so_o};
      nbits <= nbits + 5'h01;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap <= 4'hf;
    end else if ((cs_q && !spi_cs_n_i) || (sclk_q && !spi_sclk_i)) begin
      gap <= 4'h0;
    end else if (gap != 4'hf) begin
      gap <= gap + 4'h1;
    end
  end
  assign done = !cs_q && spi_cs_n_i && (nbits == FRAME_BITS);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence frame_start_s;
    $fell(spi_cs_n_i);
  endsequence
  sequence frame_end_s;
    $rose(spi_cs_n_i);
  endsequence
  oe_drive_on_a: assert property (frame_start_s |-> ##[1:4] !spi_so_oe_n_o) else $error("so enable late");
  oe_release_a: assert property (frame_end_s |-> ##[1:5] spi_so_oe_n_o) else $error("so enable held");
  oe_idle_a: assert property (spi_cs_n_i [*8] |-> spi_so_oe_n_o) else $error("so driven when idle");
  so_timing_a: assert property (!spi_cs_n_i && $changed(spi_so_o) |-> gap <= 4'h6) else $error("so moved late");
  fail_bit_a: assert property (done && word != WORD_ZERO |-> word[SO_FAIL_BIT] == fail_state_indicator_i)
    else $error("fail bit wrong");
  id_word_a: assert property (done && word[15:12] == ADDR_PART |->
    word[10:0] == {3'h0, dev_raw_i.undervoltage_flag ? PART_CODE_UV : PART_CODE}) else $error("id word wrong");
  io_word_a: assert property (done && word[15:12] == ADDR_IO |-> word[10:0] == {1'b0, |io_raw_i.toggle_inputs,
    io_raw_i.control_input_state, io_raw_i.output_level_bit}) else $error("io word wrong");
  dev_word_a: assert property (done && word[15:12] == ADDR_DEVICE |->
    word[7:5] == 3'h0 && word[0] == dev_raw_i.limp_input_state) else $error("device word wrong");
  chan_res_a: assert property (done && word[15:12] inside {[ADDR_CH_FIRST:ADDR_CH_LAST]} |-> !word[7])
    else $error("channel reserved bit set");
  quick_dsf_a: assert property (done && word[15:12] == ADDR_QUICK |-> !word[4] && (!(|word[7:5]) || word[10]))
    else $error("quick word summary wrong");
endmodule // sfs_checker
bind sfs_status_readout sfs_checker #(.PART_CODE(PART_CODE)) i_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .spi_cs_n_i(spi_cs_n_i), .spi_sclk_i(spi_sclk_i), .spi_so_o(spi_so_o), .spi_so_oe_n_o(spi_so_oe_n_o),
  .fail_state_indicator_i(fail_state_indicator_i), .dev_raw_i(dev_raw_i), .io_raw_i(io_raw_i));

/* File: bench/sfs_host_model.sv */
// SPI host model: frames of up to 16 bits, MSB first, link clock idle low
`timescale 1ns/1ps
module sfs_host_model (
  input  wire logic sys_clk_i,
  input  wire logic spi_so_i,
  output logic      spi_cs_n_o,
  output logic      spi_sclk_o,
  output logic      spi_si_o
);
  initial begin
    spi_cs_n_o = 1'b1;
    spi_sclk_o = 1'b0;
    spi_si_o   = 1'b0;
  end
  // Edges sit 3 ns past a core edge, so no race with sampling
  task automatic xfer(input logic [15:0] si_word, input int nbits, output logic [15:0] so_word);
    so_word = 16'h0000;
    @(posedge sys_clk_i);
    #3;
    spi_cs_n_o = 1'b0;
    #150;
    for (int i = 0; i < nbits; i++) begin
      #50;
      spi_si_o = si_word[15 - i];
      #50;
      spi_sclk_o = 1'b1;
      #99;
      so_word = {so_word[14:0], spi_so_i};
      #1;
      spi_sclk_o = 1'b0;
    end
    #100;
    spi_cs_n_o = 1'b1;
    // Released data line must not look like a held value
    spi_si_o = ~spi_si_o;
    #300;
  endtask
endmodule // sfs_host_model

/* File: bench/tb.sv */
// Self-checking bench for the status readout with an SPI host model
`timescale 1ns/1ps
module tb;
  import sfs_pkg::*;
  typedef struct packed {
    logic [3:0]  sel;
    logic        fm;
    sfs_io_raw_t io;
    logic [15:0] exp;
  } sfs_row_t;
  localparam logic [7:0] PART = 8'h3c; // Arbitrary value
  localparam sfs_row_t ROWS [8] = '{'{4'h8, 1'b0, 13'h0155, 16'h8155}, '{4'h8, 1'b1, 13'h08aa, 16'h8aaa},
    '{4'h8, 1'b0, 13'h1000, 16'h8200}, '{4'h9, 1'b0, 13'h0000, 16'h903c}, '{4'h9, 1'b1, 13'h0000, 16'h983c},
    '{4'h1, 1'b1, 13'h0000, 16'h1c40}, '{4'h6, 1'b0, 13'h0000, 16'h0000}, '{4'hf, 1'b0, 13'h0000, 16'h0000}};
  logic                         sys_clk_i;
  logic                         rst_n_i = 1'b0;
  logic                         fm = 1'b0;
  logic                         srr = 1'b0;
  logic                         cs_n, sclk, si, so, oe_n, dgl;
  sfs_chan_flags_t [NUM_CH-1:0] chan_raw = '0;
  sfs_dev_raw_t                 dev_raw = '0;
  sfs_io_raw_t                  io_raw = '0;
  logic [15:0]                  so_w;
  logic [15:0]                  prev = 16'h1440;
  int                           fail_count = 0;
  int                           n_compared = 0;
  sfs_status_readout #(.OPEN_ON_SLOW(40), .OPEN_ON_FAST(10), .PART_CODE(PART)) i_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_si_i(si),
    .spi_so_o(so), .spi_so_oe_n_o(oe_n), .fail_state_indicator_i(fm), .serial_regs_reset_i(srr),
    .chan_raw_i(chan_raw), .dev_raw_i(dev_raw), .io_raw_i(io_raw), .open_on_deglitch_select_o(dgl));
  sfs_host_model i_host (.sys_clk_i(sys_clk_i), .spi_so_i(so), .spi_cs_n_o(cs_n), .spi_sclk_o(sclk), .spi_si_o(si));
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic frame(input logic [15:0] si_w, input logic [15:0] exp);
    i_host.xfer(si_w, 16, so_w);
    check("so word", so_w, exp);
  endtask
  task automatic hold_raw(input int ch, input sfs_chan_flags_t v, input int n);
    @(posedge sys_clk_i);
    chan_raw[ch] <= v;
    repeat (n) @(posedge sys_clk_i);
    chan_raw[ch] <= '0;
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    tick(100000);
    fail_count++;
    $display("timeout");
    test_done();
  end
  initial begin
    tick(8);
    rst_n_i <= 1'b1;
    tick(4);
    foreach (ROWS[i]) begin
      frame(16'h0010 | ROWS[i].sel, prev);
      @(posedge sys_clk_i);
      fm     <= ROWS[i].fm;
      io_raw <= ROWS[i].io;
      tick(6);
      frame(16'hf000, ROWS[i].exp);
      frame(16'hf000, ROWS[i].exp);
      prev = ROWS[i].exp;
    end
    fm <= 1'b0;
    $display("test rows done");
    for (int c = 1; c <= 7; c++) hold_raw(1, {2'b10, 3'(c), 2'b00}, 5);
    frame(16'h0000, 16'h0000);
    frame(16'h0003, 16'h1642);
    frame(16'hf000, 16'h3658);
    frame(16'hf000, 16'h1440);
    $display("test overcurrent done");
    hold_raw(0, 7'h01, 100);
    hold_raw(0, 7'h01, 140);
    hold_raw(0, 7'h02, 20);
    frame(16'h0002, 16'h1541);
    frame(16'hf000, 16'h2501);
    frame(16'h0020, 16'h1440);
    check("deglitch select", {15'h0, dgl}, 16'h0001);
    hold_raw(0, 7'h02, 8);
    hold_raw(0, 7'h02, 20);
    frame(16'h0022, 16'h1541);
    frame(16'hf000, 16'h2502);
    frame(16'hf000, 16'h1440);
    $display("test open load done");
    i_host.xfer(16'h0007, 12, so_w);
    @(posedge sys_clk_i);
    dev_raw <= 6'h3f;
    tick(5);
    dev_raw <= 6'h01;
    tick(4);
    frame(16'h0007, 16'h14e0);
    frame(16'h0009, 16'h741f);
    dev_raw <= 6'h08;
    tick(4);
    frame(16'hf000, 16'h9000);
    $display("test device done");
    dev_raw <= 6'h00;
    rst_n_i <= 1'b0;
    tick(4);
    check("reset pins", {13'h0, so, oe_n, dgl}, 16'h0002);
    tick(4);
    rst_n_i <= 1'b1;
    tick(4);
    frame(16'h0007, 16'h1440);
    frame(16'hf000, 16'h7400);
    frame(16'hf000, 16'h1000);
    @(posedge sys_clk_i);
    srr <= 1'b1;
    tick(4);
    srr <= 1'b0;
    tick(4);
    frame(16'hf000, 16'h1440);
    $display("test reset done");
    test_done();
  end
endmodule // tb
